// [hdl/upconv_regs_defs.svh]
// Offsets, field positions and reset values of the upper register map
`ifndef UPCONV_REGS_DEFS_SVH
`define UPCONV_REGS_DEFS_SVH
`define ADDR_AMP_SCALE 9'h009
`define ADDR_SYNC 9'h00a
`define ADDR_PROFILE_FIRST 9'h00e
`define ADDR_PROFILE_LAST 9'h015
`define ADDR_RAM_PORT 9'h016
`define ADDR_PIN_DIR 9'h018
`define ADDR_PIN_DATA 9'h198
`define AMP_RATE_HI 31
`define AMP_RATE_LO 16
`define AMP_SCALE_HI 15
`define AMP_SCALE_LO 2
`define AMP_STEP_HI 1
`define AMP_STEP_LO 0
`define SYNC_VALID_HI 31
`define SYNC_VALID_LO 28
`define SYNC_RX_EN 27
`define SYNC_GEN_EN 26
`define SYNC_GEN_POL 25
`define SYNC_PRESET_HI 23
`define SYNC_PRESET_LO 18
`define SYNC_GEN_DLY_HI 15
`define SYNC_GEN_DLY_LO 11
`define SYNC_RX_DLY_HI 7
`define SYNC_RX_DLY_LO 3
`define SYNC_WMASK 32'hfefcf8f8
`define AMP_RESET 32'h0000_0000
`define SYNC_RESET 32'h0000_0000
`define PROFILE_RESET 64'h0000_0000_0000_0000
`define PIN_DIR_RESET 16'h0000
`define ST_AMP_HI 61
`define ST_AMP_LO 48
`define ST_WMASK 64'h3fff_ffff_ffff_ffff
`define PH_HI 47
`define PH_LO 32
`define FTW_HI 31
`define FTW_LO 0
`define QD_INTERP_HI 63
`define QD_INTERP_LO 58
`define QD_INVERT 57
`define QD_ICCI_BYP 56
`define QD_OSF_HI 55
`define QD_OSF_LO 48
`define MODE_QUAD 2'b00
`define MODE_SINGLE 2'b01
`define MODE_INTERP 2'b10
`define AMP_MAX 14'h3fff
`define AMP_RATE_ONE 16'h0001
`endif

// [hdl/upconv_regs_pkg.sv]
// Types shared by the upper register map
package upconv_regs_pkg;
   typedef enum logic [1:0] {ramp_idle, ramp_up, ramp_down} ramp_state_type;
   typedef logic [63:0] profile_type;
endpackage : upconv_regs_pkg

// [hdl/upconv_regs.sv]
// Amplitude, sync, profile, RAM port and pin-direction registers
`timescale 1ns/1ps
`default_nettype none
`include "upconv_regs_defs.svh"
// What this block does
// [RULE_01] Amplitude register effective only when scaling enabled
// [RULE_02] Ramp rate paces ramp updates, ramp only
// [RULE_03] No ramp, no keying: scale applied directly
// [RULE_04] Manual keying: scale applied while keying pin high
// [RULE_05] Ramping: scale field is amplitude ceiling
// [RULE_06] Step size picks ramp increment, ramp only
// [RULE_07] Validation delay field, four bits, reset zero
// [RULE_08] Bit 27 enables sync receiver, reset off
// [RULE_09] Bit 26 enables sync generator, reset off
// [RULE_10] Bit 25 picks generator clock edge
// [RULE_11] Sync pulse loads six-bit state preset
// [RULE_12] Generator delay field, five bits, reset zero
// [RULE_13] Receiver delay field, five bits, reset zero
// [RULE_14] Eight consecutive profiles, layout set by mode
// [RULE_15] Profile pins select the active profile
// [RULE_16] Single tone: amplitude, phase, frequency fields
// [RULE_17] Quadrature: interpolation and output scale fields
// [RULE_18] Bit 57 selects modulator sign
// [RULE_19] Bit 56 bypasses inverse comb filter
// [RULE_20] Interpolating mode uses only three fields
// [RULE_21] RAM port word count from segment addresses
// [RULE_22] Pin data bits follow direction config
// [RULE_23] Trigger edges select RAM segment zero/one
// [RULE_24] Unassigned bits ignore writes, read zero
module upconv_regs #(
   parameter int PROFILES = 8,
   parameter int RAM_AW = 10
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [8:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   output logic [63:0] reg_rdata,
   output logic reg_hit,
   input wire logic amplitude_scaling_en,
   input wire logic amplitude_ramp_en,
   input wire logic amplitude_keying_manual,
   input wire logic amplitude_keying,
   input wire logic [1:0] operating_mode,
   input wire logic ram_enable,
   input wire logic ram_trigger_pin,
   input wire logic [2:0] profile_pins,
   input wire logic sync_pulse,
   input wire logic [RAM_AW-1:0] seg0_start,
   input wire logic [RAM_AW-1:0] seg0_end,
   input wire logic [RAM_AW-1:0] seg1_start,
   input wire logic [RAM_AW-1:0] seg1_end,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe_n,
   output logic [13:0] synth_amplitude,
   output logic [31:0] freq_word,
   output logic [15:0] phase_word,
   output logic [7:0] output_scale,
   output logic [5:0] interp_factor,
   output logic spectral_invert,
   output logic inv_comb_bypass,
   output logic [3:0] sync_valid_delay,
   output logic sync_rx_enable,
   output logic sync_gen_enable,
   output logic sync_gen_falling,
   output logic [4:0] sync_gen_delay,
   output logic [4:0] sync_rx_delay,
   output logic [5:0] sync_state,
   output logic ram_segment_sel,
   output logic ram_wr,
   output logic [RAM_AW-1:0] ram_waddr,
   output logic [31:0] ram_wdata,
   output logic ram_port_busy
);
   import upconv_regs_pkg::*;

   logic [31:0] amp_q;
   logic [31:0] sync_q;
   profile_type profile_q [PROFILES];
   logic [15:0] dir_q;
   logic [15:0] dout_q;
   logic [5:0] sync_state_q;
   logic trig_q;
   logic seg_q;
   logic [RAM_AW-1:0] waddr_q;
   logic [RAM_AW-1:0] wend_q;
   logic busy_q;
   logic ram_wr_q;
   logic [31:0] ram_wdata_q;
   logic [13:0] amp_q_ramp;
   logic [15:0] ramp_cnt_q;
   ramp_state_type ramp_q;
   logic [63:0] rdata_q;
   logic [13:0] amp_out_q;
   profile_type act;
   logic [13:0] ceiling;
   logic [13:0] step;

   function automatic logic prof_hit(input logic [8:0] a);
      prof_hit = (a >= `ADDR_PROFILE_FIRST) && (a <= `ADDR_PROFILE_LAST);
   endfunction : prof_hit

   function automatic logic [13:0] step_of(input logic [1:0] s);
      step_of = 14'h0001 << s;
   endfunction : step_of

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_q <= `AMP_RESET;
      end else if (reg_wr && reg_addr == `ADDR_AMP_SCALE) begin
         amp_q <= reg_wdata[31:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_q <= `SYNC_RESET; // [RULE_07] [RULE_08] [RULE_09] [RULE_12] [RULE_13]
      end else if (reg_wr && reg_addr == `ADDR_SYNC) begin
         sync_q <= reg_wdata[31:0] & `SYNC_WMASK; // [RULE_24]
      end
   end

   // One layout for all slots; which bits are held depends on mode at write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < PROFILES; i++) begin
            profile_q[i] <= `PROFILE_RESET;
         end
      end else if (reg_wr && prof_hit(reg_addr)) begin
         for (int i = 0; i < PROFILES; i++) begin
            if (reg_addr - `ADDR_PROFILE_FIRST == 9'(i)) begin // [RULE_14]
               if (operating_mode == `MODE_SINGLE) begin
                  profile_q[i] <= reg_wdata & `ST_WMASK; // [RULE_16] [RULE_24]
               end else begin
                  profile_q[i] <= reg_wdata; // [RULE_17]
               end
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dir_q <= `PIN_DIR_RESET;
      end else if (reg_wr && reg_addr == `ADDR_PIN_DIR) begin
         dir_q <= reg_wdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dout_q <= 16'h0000;
      end else if (reg_wr && reg_addr == `ADDR_PIN_DATA) begin
         dout_q <= reg_wdata[15:0]; // Only bits set as outputs reach pins
      end
   end

   assign pin_out = dout_q;
   assign pin_oe_n = ~dir_q; // [RULE_22]

   // Sync state generator: preset on sync pulse while receiver enabled, else counts while generator enabled
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_state_q <= 6'h00;
      end else if (sync_pulse && sync_q[`SYNC_RX_EN]) begin
         sync_state_q <= sync_q[`SYNC_PRESET_HI:`SYNC_PRESET_LO]; // [RULE_11]
      end else if (sync_q[`SYNC_GEN_EN]) begin
         sync_state_q <= sync_state_q + 6'h01;
      end
   end

   assign sync_valid_delay = sync_q[`SYNC_VALID_HI:`SYNC_VALID_LO]; // [RULE_07]
   assign sync_rx_enable = sync_q[`SYNC_RX_EN]; // [RULE_08]
   assign sync_gen_enable = sync_q[`SYNC_GEN_EN]; // [RULE_09]
   assign sync_gen_falling = sync_q[`SYNC_GEN_POL]; // [RULE_10]
   assign sync_gen_delay = sync_q[`SYNC_GEN_DLY_HI:`SYNC_GEN_DLY_LO]; // [RULE_12]
   assign sync_rx_delay = sync_q[`SYNC_RX_DLY_HI:`SYNC_RX_DLY_LO]; // [RULE_13]
   assign sync_state = sync_state_q;

   // RAM segment pick on trigger edges
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trig_q <= 1'b0;
         seg_q <= 1'b0;
      end else begin
         trig_q <= ram_trigger_pin;
         if (ram_enable && ram_trigger_pin && !trig_q) begin
            seg_q <= 1'b0; // [RULE_23]
         end else if (ram_enable && !ram_trigger_pin && trig_q) begin
            seg_q <= 1'b1; // [RULE_23]
         end
      end
   end

   assign ram_segment_sel = seg_q;

   // RAM port: first write arms the span, words then fill start..end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         waddr_q <= '0;
         wend_q <= '0;
         ram_wr_q <= 1'b0;
         ram_wdata_q <= 32'h0000_0000;
      end else begin
         ram_wr_q <= 1'b0;
         if (reg_wr && reg_addr == `ADDR_RAM_PORT) begin
            ram_wr_q <= 1'b1;
            ram_wdata_q <= reg_wdata[31:0];
            if (!busy_q) begin
               waddr_q <= seg_q ? seg1_start : seg0_start; // [RULE_21]
               wend_q <= seg_q ? seg1_end : seg0_end;
               busy_q <= (seg_q ? seg1_start : seg0_start) != (seg_q ? seg1_end : seg0_end);
            end else begin
               waddr_q <= waddr_q + 1'b1;
               busy_q <= (waddr_q + 1'b1) != wend_q; // [RULE_21]
            end
         end
      end
   end

   assign ram_wr = ram_wr_q;
   assign ram_waddr = waddr_q;
   assign ram_wdata = ram_wdata_q;
   assign ram_port_busy = busy_q;

   assign act = profile_q[profile_pins]; // [RULE_15]
   assign ceiling = amp_q[`AMP_SCALE_HI:`AMP_SCALE_LO];
   assign step = step_of(amp_q[`AMP_STEP_HI:`AMP_STEP_LO]); // [RULE_06]

   // Amplitude ramp: keying pin steers direction, capped at the ceiling
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ramp_q <= ramp_idle;
         ramp_cnt_q <= 16'h0000;
         amp_q_ramp <= 14'h0000;
      end else if (!(amplitude_scaling_en && amplitude_ramp_en)) begin
         ramp_q <= ramp_idle;
         ramp_cnt_q <= 16'h0000;
         amp_q_ramp <= 14'h0000;
      end else begin
         ramp_q <= amplitude_keying ? ramp_up : ramp_down;
         if (ramp_cnt_q + `AMP_RATE_ONE >= amp_q[`AMP_RATE_HI:`AMP_RATE_LO]) begin // [RULE_02]
            ramp_cnt_q <= 16'h0000;
            case (ramp_q)
               ramp_up: begin
                  if ({1'b0, amp_q_ramp} + {1'b0, step} >= {1'b0, ceiling}) begin
                     amp_q_ramp <= ceiling; // [RULE_05]
                  end else begin
                     amp_q_ramp <= amp_q_ramp + step; // [RULE_06]
                  end
               end
               ramp_down: begin
                  amp_q_ramp <= (amp_q_ramp > step) ? amp_q_ramp - step : 14'h0000;
               end
               default: begin
                  amp_q_ramp <= amp_q_ramp;
               end
            endcase
         end else begin
            ramp_cnt_q <= ramp_cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_out_q <= 14'h0000;
      end else if (!amplitude_scaling_en) begin
         amp_out_q <= (operating_mode == `MODE_SINGLE) ? act[`ST_AMP_HI:`ST_AMP_LO] : `AMP_MAX; // [RULE_01]
      end else if (amplitude_ramp_en) begin
         amp_out_q <= amp_q_ramp; // [RULE_05]
      end else if (!amplitude_keying_manual) begin
         amp_out_q <= ceiling; // [RULE_03]
      end else begin
         amp_out_q <= amplitude_keying ? ceiling : 14'h0000; // [RULE_04]
      end
   end

   assign synth_amplitude = amp_out_q;

   // Interpolating mode passes only scale, factor and bypass
   always_comb begin
      freq_word = act[`FTW_HI:`FTW_LO];
      phase_word = act[`PH_HI:`PH_LO];
      output_scale = act[`QD_OSF_HI:`QD_OSF_LO];
      interp_factor = act[`QD_INTERP_HI:`QD_INTERP_LO]; // [RULE_17]
      spectral_invert = act[`QD_INVERT]; // [RULE_18]
      inv_comb_bypass = act[`QD_ICCI_BYP]; // [RULE_19]
      if (operating_mode == `MODE_SINGLE) begin
         output_scale = 8'h00;
         interp_factor = 6'h00;
         spectral_invert = 1'b0;
         inv_comb_bypass = 1'b0;
      end else if (operating_mode == `MODE_INTERP) begin
         freq_word = 32'h0000_0000; // [RULE_20]
         phase_word = 16'h0000;
         spectral_invert = 1'b0;
      end
   end

   // Read mux, registered one cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 64'h0000_0000_0000_0000;
      end else if (reg_rd) begin
         rdata_q <= 64'h0000_0000_0000_0000; // [RULE_24]
         if (reg_addr == `ADDR_AMP_SCALE) begin
            rdata_q <= {32'h0000_0000, amp_q};
         end else if (reg_addr == `ADDR_SYNC) begin
            rdata_q <= {32'h0000_0000, sync_q};
         end else if (prof_hit(reg_addr)) begin
            rdata_q <= profile_q[3'(reg_addr - `ADDR_PROFILE_FIRST)];
         end else if (reg_addr == `ADDR_PIN_DIR) begin
            rdata_q <= {48'h0, dir_q};
         end else if (reg_addr == `ADDR_PIN_DATA) begin
            rdata_q <= {48'h0, (dir_q & dout_q) | (~dir_q & pin_in)}; // [RULE_22]
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_hit = (reg_addr == `ADDR_AMP_SCALE) || (reg_addr == `ADDR_SYNC)
      || prof_hit(reg_addr) || (reg_addr == `ADDR_RAM_PORT)
      || (reg_addr == `ADDR_PIN_DIR) || (reg_addr == `ADDR_PIN_DATA);
endmodule : upconv_regs
`default_nettype wire

// [testbench/upconv_regs_props.sv]
// Port-level assertions for the upper register map
`timescale 1ns/1ps
`default_nettype none
`include "upconv_regs_defs.svh"
module upconv_regs_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [8:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic [63:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic amplitude_scaling_en,
   input wire logic amplitude_ramp_en,
   input wire logic amplitude_keying_manual,
   input wire logic [1:0] operating_mode,
   input wire logic ram_enable,
   input wire logic ram_trigger_pin,
   input wire logic sync_pulse,
   input wire logic [15:0] pin_oe_n,
   input wire logic [13:0] synth_amplitude,
   input wire logic [31:0] freq_word,
   input wire logic [15:0] phase_word,
   input wire logic spectral_invert,
   input wire logic sync_rx_enable,
   input wire logic sync_gen_enable,
   input wire logic sync_gen_falling,
   input wire logic [5:0] sync_state,
   input wire logic ram_segment_sel,
   input wire logic ram_wr,
   input wire logic [31:0] ram_wdata
);
   logic [13:0] scale_q;
   logic [5:0] preset_q;
   logic wa_s, wa_y, amp_dir;
   assign wa_s = reg_wr && reg_addr == `ADDR_AMP_SCALE;
   assign wa_y = reg_wr && reg_addr == `ADDR_SYNC;
   assign amp_dir = amplitude_scaling_en && !amplitude_ramp_en && !amplitude_keying_manual;
   // Shadows of fields that reach no port
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scale_q <= 14'h0000;
      end else if (wa_s) begin
         scale_q <= reg_wdata[15:2];
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         preset_q <= 6'h00;
      end else if (wa_y) begin
         preset_q <= reg_wdata[23:18];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_sync_rx_bit: assert property (
      wa_y |=> sync_rx_enable == $past(reg_wdata[27])) else $error("rx enable wrong");
   a_sync_gen_bits: assert property (
      wa_y |=> {sync_gen_enable, sync_gen_falling} == $past(reg_wdata[26:25]))
      else $error("generator bits wrong");
   a_sync_preset_load: assert property (
      sync_pulse && sync_rx_enable && !sync_gen_enable && !wa_y |=> sync_state == preset_q)
      else $error("preset not loaded");
   a_pin_dir_map: assert property (
      reg_wr && reg_addr == `ADDR_PIN_DIR |=> pin_oe_n == ~$past(reg_wdata[15:0]))
      else $error("pin enables wrong");
   a_unmapped_read_zero: assert property (
      reg_rd && !reg_hit |=> reg_rdata == 64'h0) else $error("unmapped read not zero");
   a_ram_port_write: assert property (
      reg_wr && reg_addr == `ADDR_RAM_PORT |=> ram_wr && ram_wdata == $past(reg_wdata[31:0]))
      else $error("ram write missing");
   a_seg_rise_zero: assert property (
      ram_enable && $rose(ram_trigger_pin) |-> ##[1:2] !ram_segment_sel)
      else $error("rise did not pick segment zero");
   a_seg_fall_one: assert property (
      ram_enable && $fell(ram_trigger_pin) |-> ##[1:2] ram_segment_sel)
      else $error("fall did not pick segment one");
   a_interp_ignored: assert property (
      operating_mode == `MODE_INTERP |-> freq_word == 32'h0 && phase_word == 16'h0
      && !spectral_invert) else $error("interp mode leaks fields");
   a_amp_direct: assert property (
      (amp_dir && !wa_s) ##1 amp_dir |-> synth_amplitude == scale_q)
      else $error("direct amplitude wrong");
endmodule : upconv_regs_props
bind upconv_regs upconv_regs_props u_props (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_hit, .amplitude_scaling_en, .amplitude_ramp_en,
   .amplitude_keying_manual, .operating_mode, .ram_enable, .ram_trigger_pin, .sync_pulse,
   .pin_oe_n, .synth_amplitude, .freq_word, .phase_word, .spectral_invert, .sync_rx_enable,
   .sync_gen_enable, .sync_gen_falling, .sync_state, .ram_segment_sel, .ram_wr, .ram_wdata);
`default_nettype wire

// [testbench/upconv_host.sv]
// Host controller model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module upconv_host (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [8:0] reg_addr,
   output logic [63:0] reg_wdata,
   input wire logic [63:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 9'h1ff;
      reg_wdata = 64'h0;
   end
   // Idle bus shows inverted values so stale data never passes as valid
   task automatic wr(input logic [8:0] a, input logic [63:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [63:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : upconv_host
`default_nettype wire

// [testbench/upconv_regs_tb_top.sv]
// Self-checking bench for the upper register map
`timescale 1ns/1ps
`default_nettype none
`include "upconv_regs_defs.svh"
module upconv_regs_tb_top;
   logic clk, sys_rst, reg_wr, reg_rd, reg_hit, amplitude_scaling_en, amplitude_ramp_en;
   logic amplitude_keying_manual, amplitude_keying, ram_enable, ram_trigger_pin, sync_pulse;
   logic spectral_invert, inv_comb_bypass, sync_rx_enable, sync_gen_enable, sync_gen_falling;
   logic ram_segment_sel, ram_wr, ram_port_busy;
   logic [1:0] operating_mode;
   logic [2:0] profile_pins;
   logic [3:0] sync_valid_delay;
   logic [4:0] sync_gen_delay, sync_rx_delay;
   logic [5:0] interp_factor, sync_state;
   logic [7:0] output_scale;
   logic [8:0] reg_addr;
   logic [9:0] seg0_start, seg0_end, seg1_start, seg1_end, ram_waddr;
   logic [13:0] synth_amplitude;
   logic [15:0] pin_in, pin_out, pin_oe_n, phase_word;
   logic [31:0] freq_word, ram_wdata;
   logic [63:0] reg_wdata, reg_rdata, rv;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   upconv_regs DUT (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_hit, .amplitude_scaling_en, .amplitude_ramp_en, .amplitude_keying_manual,
      .amplitude_keying, .operating_mode, .ram_enable, .ram_trigger_pin, .profile_pins,
      .sync_pulse, .seg0_start, .seg0_end, .seg1_start, .seg1_end, .pin_in, .pin_out,
      .pin_oe_n, .synth_amplitude, .freq_word, .phase_word, .output_scale, .interp_factor,
      .spectral_invert, .inv_comb_bypass, .sync_valid_delay, .sync_rx_enable,
      .sync_gen_enable, .sync_gen_falling, .sync_gen_delay, .sync_rx_delay, .sync_state,
      .ram_segment_sel, .ram_wr, .ram_waddr, .ram_wdata, .ram_port_busy);
   upconv_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [63:0] prof(input int k);
      return {2'b11, 14'h0a00 + 14'(k), 16'h5500 + 16'(k), 32'hc0de_0000 + 32'(k)};
   endfunction : prof
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   // The full run needs about 900 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      sys_rst = 1'b1;
      {amplitude_scaling_en, amplitude_ramp_en, amplitude_keying_manual} = 3'b000;
      {amplitude_keying, ram_enable, ram_trigger_pin, sync_pulse} = 4'h0;
      {seg0_start, seg0_end, seg1_start, seg1_end} = 40'h0;
      operating_mode = `MODE_SINGLE;
      profile_pins = 3'h0;
      pin_in = 16'h3c3c;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk(pin_oe_n, 16'hffff);
      host.rd(`ADDR_SYNC, rv);
      chk(rv, 64'h0);
      host.rd(`ADDR_PIN_DIR, rv);
      chk(rv, 64'h0);
      host.wr(`ADDR_SYNC, 64'hffff_ffff_ffff_ffff);
      #1;
      chk({sync_valid_delay, sync_rx_enable, sync_gen_enable, sync_gen_falling, sync_gen_delay,
         sync_rx_delay}, 17'h1ffff);
      host.rd(`ADDR_SYNC, rv);
      chk(rv, 64'hfefc_f8f8);
      host.wr(`ADDR_SYNC, 64'h08a8_0000);
      @(posedge clk);
      sync_pulse <= 1'b1;
      @(posedge clk);
      sync_pulse <= 1'b0;
      @(posedge clk);
      #1;
      chk(sync_state, 6'h2a);
      for (int k = 0; k < 8; k++) begin
         host.wr(`ADDR_PROFILE_FIRST + 9'(k), prof(k));
      end
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         profile_pins <= 3'(k);
         repeat (2) @(posedge clk);
         #1;
         chk({synth_amplitude, phase_word, freq_word}, prof(k) & `ST_WMASK);
         host.rd(`ADDR_PROFILE_FIRST + 9'(k), rv);
         chk(rv, prof(k) & `ST_WMASK);
      end
      @(posedge clk);
      amplitude_scaling_en <= 1'b1;
      host.wr(`ADDR_AMP_SCALE, 64'habcd_48d2);
      repeat (3) @(posedge clk);
      #1;
      chk(synth_amplitude, 14'h1234);
      amplitude_keying_manual <= 1'b1;
      amplitude_keying <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(synth_amplitude, 14'h1234);
      amplitude_keying_manual <= 1'b0;
      amplitude_ramp_en <= 1'b1;
      amplitude_keying <= 1'b0;
      host.wr(`ADDR_AMP_SCALE, 64'h0001_0413);
      repeat (700) @(posedge clk);
      #1;
      chk(synth_amplitude, 14'h0000);
      amplitude_keying <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      chk({synth_amplitude[2:0], synth_amplitude != 14'h0}, 4'h1);
      repeat (60) @(posedge clk);
      #1;
      chk(synth_amplitude, 14'h0104);
      operating_mode <= `MODE_QUAD;
      profile_pins <= 3'h2;
      host.wr(`ADDR_PROFILE_FIRST + 9'h2, 64'hb69c_4321_8765_4321);
      #1;
      chk({interp_factor, spectral_invert, inv_comb_bypass, output_scale, phase_word,
         freq_word}, 64'hb69c_4321_8765_4321);
      host.rd(`ADDR_PROFILE_FIRST + 9'h2, rv);
      chk(rv, 64'hb69c_4321_8765_4321);
      operating_mode <= `MODE_INTERP;
      profile_pins <= 3'h3;
      host.wr(`ADDR_PROFILE_FIRST + 9'h3, 64'h453e_1111_2222_3333);
      #1;
      chk({interp_factor, spectral_invert, inv_comb_bypass, output_scale, phase_word,
         freq_word}, 64'h453e_0000_0000_0000);
      ram_enable <= 1'b1;
      {seg0_start, seg0_end, seg1_start, seg1_end} <= {10'h005, 10'h007, 10'h003, 10'h004};
      ram_trigger_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ram_trigger_pin <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(ram_segment_sel, 1'b1);
      host.wr(`ADDR_RAM_PORT, 64'h1111_1111);
      #1;
      chk({ram_port_busy, ram_waddr}, {1'b1, 10'h003});
      host.wr(`ADDR_RAM_PORT, 64'h2222_2222);
      #1;
      chk({ram_port_busy, ram_waddr}, {1'b0, 10'h004});
      ram_trigger_pin <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(ram_segment_sel, 1'b0);
      host.wr(`ADDR_RAM_PORT, 64'h3333_3333);
      #1;
      chk(ram_waddr, 10'h005);
      host.rd(`ADDR_RAM_PORT, rv);
      chk(rv, 64'h0);
      host.wr(9'h100, 64'hffff_ffff_ffff_ffff);
      host.rd(9'h100, rv);
      chk(rv, 64'h0);
      host.wr(`ADDR_PIN_DIR, 64'h00ff);
      host.wr(`ADDR_PIN_DATA, 64'ha5a5);
      #1;
      chk(pin_oe_n, 16'hff00);
      chk(pin_out & 16'h00ff, 16'h00a5);
      host.rd(`ADDR_PIN_DATA, rv);
      chk(rv, 64'h3ca5);
      end_of_test();
   end
endmodule : upconv_regs_tb_top
`default_nettype wire
